// file: rtl/rts_pkg.sv
// Package with register map and reset values for the rate tracking synth registers
package rts_pkg;
  localparam logic [15:0] RTS_ADDR_SOF_COUNT_HIGH    = 16'hFFE3;
  localparam logic [15:0] RTS_ADDR_SOF_COUNT_LOW     = 16'hFFE4;
  localparam logic [15:0] RTS_ADDR_SYNTH_ONE_UPPER   = 16'hFFE5;
  localparam logic [15:0] RTS_ADDR_SYNTH_ONE_MIDDLE  = 16'hFFE6;
  localparam logic [15:0] RTS_ADDR_SYNTH_ONE_LOWER   = 16'hFFE7;
  localparam logic [15:0] RTS_ADDR_SYNTH_TWO_UPPER   = 16'hFFF7;
  localparam logic [15:0] RTS_ADDR_SYNTH_TWO_MIDDLE  = 16'hFFF8;
  localparam logic [15:0] RTS_ADDR_SYNTH_TWO_LOWER   = 16'hFFF9;
  localparam logic [7:0]  RTS_BYTE_RESET             = 8'h00;
  localparam logic [15:0] RTS_COUNT_RESET            = 16'h0000;
  localparam logic [23:0] RTS_FREQ_RESET             = 24'h00_0000;
  localparam logic [7:0]  RTS_UNMAPPED_READ          = 8'h00;
  // Source select codes for the snapshot counter clock
  typedef enum logic [0:0] {
    RTS_SRC_PRIMARY = 1'b0,
    RTS_SRC_ALT     = 1'b1
  } rts_src_t;
endpackage

// file: rtl/rts_regs.sv
// Rate tracking synth frequency words and frame cycle snapshot registers
//
// Summary of operation
// - Synth one word is 24 bits; middle register holds bits 15:8.
// - Synth one upper register holds bits 23:16 of its word.
// - Free-running 16-bit counter counts selected master clock cycles, wrapping.
// - On each start of frame the counter value is copied to capture registers.
// - Counter clock selects primary or alternate master clock output.
// - Low capture register shows snapshot bits 7:0, read-only.
// - High capture register shows snapshot bits 15:8, read-only.
// - Synth two word is 24 bits over three writable byte registers.
// - Synth one lower register holds the word's least significant byte.
// - Synth one word sets primary master clock rate; synth two may source it.
//
// Notes for users of this block
// Master clocks are oversampled: each level must last at least two system cycles.
// A counted edge lags its pin by about three cycles; the lag cancels between snapshots.
// Frequency bytes update as written, so a synthesizer sees mixed bytes mid-load.
// Capture bytes have no write path; writes to them and to unmapped addresses vanish.
// The source select is a pin; the count runs on when the source changes.
// A source change may add one stray count to the frame that spans it.
// Read data is registered and holds its value until the next read strobe.
`timescale 1ns/1ps
module rts_regs (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        sof_i,
  input  wire logic        mclk_pri_i,
  input  wire logic        mclk_alt_i,
  input  wire logic        mclk_sel_i,
  output logic      [23:0] synth_one_freq_o,
  output logic      [23:0] synth_two_freq_o
);
  import rts_pkg::*;

  // Frequency word storage, one byte lane per register
  logic [5:0]      lane_wr;      // One-hot lane write select
  logic [5:0][7:0] lane_ff;      // Byte lanes of both words

  // Read path
  logic [7:0]      rdata_ff;
  logic [7:0]      nxt_rdata;

  // Pins from outside the system clock domain and their synchroniser stages
  logic [2:0]      pin_raw;      // Select, alternate and primary pins
  logic [2:0]      pin_meta_ff;
  logic [2:0]      pin_sync_ff;

  // Cycle counter and frame snapshot
  logic            src_now;
  logic            src_last_ff;
  logic            src_rise;
  logic [15:0]     count_ff;
  logic            sof_ff;
  logic            sof_last_ff;
  logic            snap_load;
  logic [15:0]     snap_ff;

  // Address decode selects the byte lane that a write lands in
  // Lane map: 0 to 2 are synth one lower to upper, 3 to 5 synth two lower to upper
  always_comb begin
    lane_wr = 6'h00;
    if (wr_i) begin
      if (addr_i == RTS_ADDR_SYNTH_ONE_LOWER) begin
        lane_wr[0] = 1'b1;
      end else if (addr_i == RTS_ADDR_SYNTH_ONE_MIDDLE) begin
        lane_wr[1] = 1'b1;
      end else if (addr_i == RTS_ADDR_SYNTH_ONE_UPPER) begin
        lane_wr[2] = 1'b1;
      end else if (addr_i == RTS_ADDR_SYNTH_TWO_LOWER) begin
        lane_wr[3] = 1'b1;
      end else if (addr_i == RTS_ADDR_SYNTH_TWO_MIDDLE) begin
        lane_wr[4] = 1'b1;
      end else if (addr_i == RTS_ADDR_SYNTH_TWO_UPPER) begin
        lane_wr[5] = 1'b1;
      end else begin
        lane_wr = 6'h00; // Capture bytes and unmapped addresses take no write
      end
    end
  end

  // One register per byte lane; bytes are independent, no shadow copy of the word
  for (genvar gl = 0; gl < 6; gl++) begin : g_lane
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        lane_ff[gl] <= RTS_BYTE_RESET;
      end else if (lane_wr[gl]) begin
        lane_ff[gl] <= wdata_i;
      end
    end
  end

  // Word outputs feed the synthesizers that drive the master clock pins
  assign synth_one_freq_o = {lane_ff[2], lane_ff[1], lane_ff[0]};
  assign synth_two_freq_o = {lane_ff[5], lane_ff[4], lane_ff[3]};

  // Pins from outside the system clock domain, gathered for the synchroniser loop
  assign pin_raw = {mclk_sel_i, mclk_alt_i, mclk_pri_i};

  // Two flip-flops per pin; only the second stage is read by logic
  for (genvar gp = 0; gp < 3; gp++) begin : g_sync
    // First stage may go metastable
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        pin_meta_ff[gp] <= 1'b0;
      end else begin
        pin_meta_ff[gp] <= pin_raw[gp];
      end
    end
    // Second stage gives a settled level
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        pin_sync_ff[gp] <= 1'b0;
      end else begin
        pin_sync_ff[gp] <= pin_meta_ff[gp];
      end
    end
  end

  // Pick the counting source after synchronisation
  always_comb begin
    src_now = pin_sync_ff[0];
    case (rts_src_t'(pin_sync_ff[2]))
      RTS_SRC_PRIMARY: begin
        src_now = pin_sync_ff[0];
      end
      RTS_SRC_ALT: begin
        src_now = pin_sync_ff[1];
      end
      default: begin
        src_now = pin_sync_ff[0];
      end
    endcase
  end

  // Level of the chosen clock one system cycle ago
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_last_ff <= 1'b0;
    end else begin
      src_last_ff <= src_now;
    end
  end

  // Rising edge of the chosen clock; reset level matches the idle pin, no false edge
  assign src_rise = src_now && !src_last_ff;

  // Free-running cycle counter, one step per rising edge, wraps at 16 bits
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_ff <= RTS_COUNT_RESET;
    end else if (src_rise) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // Frame event is registered so capture lands on a settled count
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sof_ff <= 1'b0;
    end else begin
      sof_ff <= sof_i;
    end
  end

  // Previous frame event level, so an event held high captures only once
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sof_last_ff <= 1'b0;
    end else begin
      sof_last_ff <= sof_ff;
    end
  end

  // Capture strobe on the first cycle of a frame event
  assign snap_load = sof_ff && !sof_last_ff;

  // Whole 16-bit snapshot taken in one cycle so both bytes match
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      snap_ff <= RTS_COUNT_RESET;
    end else if (snap_load) begin
      snap_ff <= count_ff;
    end
  end

  // Read multiplexer; capture bytes have no write path
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_i) begin
      if (addr_i == RTS_ADDR_SOF_COUNT_LOW) begin
        nxt_rdata = snap_ff[7:0];
      end else if (addr_i == RTS_ADDR_SOF_COUNT_HIGH) begin
        nxt_rdata = snap_ff[15:8];
      end else if (addr_i == RTS_ADDR_SYNTH_ONE_LOWER) begin
        nxt_rdata = lane_ff[0];
      end else if (addr_i == RTS_ADDR_SYNTH_ONE_MIDDLE) begin
        nxt_rdata = lane_ff[1];
      end else if (addr_i == RTS_ADDR_SYNTH_ONE_UPPER) begin
        nxt_rdata = lane_ff[2];
      end else if (addr_i == RTS_ADDR_SYNTH_TWO_LOWER) begin
        nxt_rdata = lane_ff[3];
      end else if (addr_i == RTS_ADDR_SYNTH_TWO_MIDDLE) begin
        nxt_rdata = lane_ff[4];
      end else if (addr_i == RTS_ADDR_SYNTH_TWO_UPPER) begin
        nxt_rdata = lane_ff[5];
      end else begin
        nxt_rdata = RTS_UNMAPPED_READ;
      end
    end else begin
      nxt_rdata = rdata_ff; // Hold until the next read strobe
    end
  end

  // Read data register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_ff <= RTS_BYTE_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;
endmodule

// file: sim/rts_mclk_src.sv
// Free-running codec master clock sources for the snapshot counter
`timescale 1ns/1ps
module rts_mclk_src (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  output logic      pri_o,
  output logic      alt_o
);
  logic [3:0] cnt_ff;
  // Primary has a period of 8 cycles, alternate 12; both run without pause
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= 4'h0;
      pri_o  <= 1'b0;
      alt_o  <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == 4'hB) ? 4'h0 : cnt_ff + 4'h1;
      if (cnt_ff[1:0] == 2'h3) pri_o <= ~pri_o;
      if (cnt_ff == 4'h5 || cnt_ff == 4'hB) alt_o <= ~alt_o;
    end
  end
endmodule

// file: sim/rts_checker.sv
// Port assertions for the synth word and read-back registers
`timescale 1ns/1ps
module rts_checker (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic [15:0] addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  wdata_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [23:0] synth_one_freq_o,
  input wire logic [23:0] synth_two_freq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Write strobe aimed at one address
  sequence s_wr(logic [15:0] a); wr_i && addr_i == a; endsequence
  property p_w1u; s_wr(16'hFFE5) |=> synth_one_freq_o[23:16] == $past(wdata_i); endproperty
  a_w1u: assert property (p_w1u) else $error("one upper");
  property p_w1m; s_wr(16'hFFE6) |=> synth_one_freq_o[15:8] == $past(wdata_i); endproperty
  a_w1m: assert property (p_w1m) else $error("one middle");
  property p_w1l; s_wr(16'hFFE7) |=> synth_one_freq_o[7:0] == $past(wdata_i); endproperty
  a_w1l: assert property (p_w1l) else $error("one lower");
  property p_w2u; s_wr(16'hFFF7) |=> synth_two_freq_o[23:16] == $past(wdata_i); endproperty
  a_w2u: assert property (p_w2u) else $error("two upper");
  property p_w2m; s_wr(16'hFFF8) |=> synth_two_freq_o[15:8] == $past(wdata_i); endproperty
  a_w2m: assert property (p_w2m) else $error("two middle");
  property p_w2l; s_wr(16'hFFF9) |=> synth_two_freq_o[7:0] == $past(wdata_i); endproperty
  a_w2l: assert property (p_w2l) else $error("two lower");
  property p_hold; !wr_i |=> $stable(synth_one_freq_o) && $stable(synth_two_freq_o); endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_rd; rd_i && addr_i == 16'hFFE6 |=> rdata_o == $past(synth_one_freq_o[15:8]); endproperty
  a_rd: assert property (p_rd) else $error("read back");
endmodule
bind rts_regs rts_checker u_chk (
  .mclk_i           (mclk_i),
  .rst_b_i          (rst_b_i),
  .addr_i           (addr_i),
  .wr_i             (wr_i),
  .rd_i             (rd_i),
  .wdata_i          (wdata_i),
  .rdata_o          (rdata_o),
  .synth_one_freq_o (synth_one_freq_o),
  .synth_two_freq_o (synth_two_freq_o)
);

// file: sim/testbench.sv
// Self-checking bench for the rate tracking synth register block
`timescale 1ns/1ps
module testbench;
  logic        mclk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, sof_i = 0, sel = 0, pri, alt;
  logic [15:0] addr_i = 16'h0000, c;
  logic [7:0]  wdata_i = 8'h00, rdata_o, v, lo;
  logic [23:0] f1, f2;
  logic [15:0] adr [6] = '{16'hFFE5, 16'hFFE6, 16'hFFE7, 16'hFFF7, 16'hFFF8, 16'hFFF9};
  logic [7:0]  dat [6] = '{8'hA5, 8'h3C, 8'h96, 8'h5A, 8'hC3, 8'h69};
  int          bad_count = 0, n_tests = 0;
  always #20 mclk_i = ~mclk_i;
  rts_mclk_src u_src (.mclk_i, .rst_b_i, .pri_o(pri), .alt_o(alt));
  rts_regs u_dut (.mclk_i, .rst_b_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o, .sof_i,
    .mclk_pri_i(pri), .mclk_alt_i(alt), .mclk_sel_i(sel),
    .synth_one_freq_o(f1), .synth_two_freq_o(f2));
  // Compare and count
  task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // One-cycle write (w=1) or read (w=0); read data lands in v
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr_i = a;
    wr_i = w;
    rd_i = !w;
    wdata_i = d;
    @(negedge mclk_i);
    wr_i = 0;
    rd_i = 0;
    @(negedge mclk_i);
    v = rdata_o;
  endtask
  // Frame pulse, then both snapshot bytes into c
  task automatic frame;
    @(negedge mclk_i);
    sof_i = 1;
    @(negedge mclk_i);
    sof_i = 0;
    acc(0, 16'hFFE4, 8'h00);
    lo = v;
    acc(0, 16'hFFE3, 8'h00);
    c = {v, lo};
  endtask
  // Count of selected clock periods between two frames gap cycles apart
  task automatic pair(input logic s, input int gap, input logic [15:0] e);
    logic [15:0] c0;
    sel = s;
    repeat (40) @(negedge mclk_i);
    frame();
    c0 = c;
    repeat (gap - 8) @(negedge mclk_i);
    frame();
    check("frame count", 16'(c - c0), e);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1ms;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(negedge mclk_i);
    rst_b_i = 1;
    for (int i = 0; i < 6; i++) begin
      acc(1, adr[i], dat[i]);
      acc(0, adr[i], 8'h00);
      check("byte", v, dat[i]);
    end
    acc(1, 16'h1234, 8'hFF);
    acc(1, 16'hFFE4, 8'hFF);
    acc(1, 16'hFFE3, 8'hFF);
    check("word one", f1, 24'hA5_3C96);
    check("word two", f2, 24'h5A_C369);
    acc(0, 16'hFFE4, 8'h00);
    check("low snapshot", v, 8'h00);
    acc(0, 16'hFFE3, 8'h00);
    check("high snapshot", v, 8'h00);
    $display("register test done");
    pair(1'b0, 800, 16'h0064);
    pair(1'b1, 960, 16'h0050);
    $display("snapshot test done");
    // Mid-run reset clears both words and the snapshot
    @(negedge mclk_i);
    rst_b_i = 0;
    repeat (2) @(negedge mclk_i);
    rst_b_i = 1;
    check("reset word one", f1, 24'h00_0000);
    check("reset word two", f2, 24'h00_0000);
    acc(0, 16'hFFE4, 8'h00);
    check("reset snapshot", v, 8'h00);
    $display("reset test done");
    complete_run();
  end
endmodule
